//--- bridge_driver_model.sv
`timescale 1ns/1ps
// Gate driver stage on the far side of the four outputs
module bridge_driver_model (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [3:0] i_gate,
    input wire logic i_fault,
    output logic o_trip_n,
    output logic [3:0] o_gate
);
    logic fault_r;
    logic [3:0] gate_r;

    // Fault line is driven high while no fault is latched and low one clock after i_fault is set
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            fault_r <= 1'b0;
            gate_r <= 4'h0;
        end else begin
            fault_r <= i_fault;
            gate_r <= i_gate;
        end
    end

    assign o_trip_n = !fault_r;
    // Gate levels as latched by the driver stage
    assign o_gate = gate_r;
endmodule : bridge_driver_model

//--- hbridge_pwm_output_select.sv
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module hbridge_pwm_output_select #(
    parameter logic [15:0] PERIOD_RESET = 16'h00ff
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire hbridge_pwm_pkg::axil_req_t i_axil,
    output hbridge_pwm_pkg::axil_rsp_t o_axil,
    input wire logic i_trip_n,
    output logic [hbridge_pwm_pkg::N_OUT-1:0] o_pwm,
    output logic [hbridge_pwm_pkg::N_OUT-1:0] o_pin_is_pwm,
    output logic o_irq
);
    import hbridge_pwm_pkg::*;

    function automatic logic [3:0] reg_sel(input logic [ADDR_W-1:0] a);
        logic [3:0] s;
        s = SEL_NONE;
        if (a == OFF_CTRL) s = SEL_CTRL;
        if (a == OFF_PERIOD) s = SEL_PERIOD;
        if (a == OFF_TRIP_CLR) s = SEL_TRIP_CLR;
        if (a == OFF_STATUS) s = SEL_STATUS;
        if (a == OFF_MASK) s = SEL_MASK;
        if (a == OFF_PIN_FUNC) s = SEL_PIN_FUNC;
        for (int k = 0; k < N_CMP; k++) begin
            if (a == OFF_CMP[k]) s = SEL_CMP0 + 4'(k);
        end
        return s;
    endfunction : reg_sel

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] st);
        logic [15:0] m;
        m = old;
        if (st[0]) m[7:0] = d[7:0];
        if (st[1]) m[15:8] = d[15:8];
        return m;
    endfunction : merge16

    ////////////////////////////////////////////////////////////////////
    // Reset release and trip pin synchroniser
    logic rst_s1_r;
    logic rst_n;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_s1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n <= rst_s1_r;
        end
    end

    logic trip_s1_r;
    logic trip_s2_r;
    logic trip_s3_r;
    logic trip_lvl_r;
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            trip_s1_r <= 1'b1;
            trip_s2_r <= 1'b1;
            trip_s3_r <= 1'b1;
            trip_lvl_r <= 1'b1;
        end else if (i_ce) begin
            trip_s1_r <= i_trip_n;
            trip_s2_r <= trip_s1_r;
            trip_s3_r <= trip_s2_r;
            if (trip_s2_r == trip_s3_r) trip_lvl_r <= trip_s3_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave
    logic aw_held_r;
    logic w_held_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [DATA_W-1:0] w_data_r;
    logic [3:0] w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [DATA_W-1:0] rdata_r;
    logic [1:0] rresp_r;

    wire awready = i_ce && !aw_held_r;
    wire wready = i_ce && !w_held_r;
    wire arready = i_ce && !rvalid_r;
    wire do_write = i_ce && aw_held_r && w_held_r && !bvalid_r;
    wire do_read = arready && i_axil.arvalid;
    wire [3:0] wsel = reg_sel(aw_addr_r);
    wire [3:0] rsel = reg_sel(i_axil.araddr);
    wire wr_ctrl = do_write && wsel == SEL_CTRL;
    wire wr_period = do_write && wsel == SEL_PERIOD;
    wire wr_trip_clr = do_write && wsel == SEL_TRIP_CLR;
    wire wr_status = do_write && wsel == SEL_STATUS;
    wire wr_mask = do_write && wsel == SEL_MASK;
    wire wr_pin = do_write && wsel == SEL_PIN_FUNC;

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= '0;
            w_strb_r <= '0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (i_ce) begin
            if (awready && i_axil.awvalid) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= i_axil.awaddr;
            end
            if (wready && i_axil.wvalid) begin
                w_held_r <= 1'b1;
                w_data_r <= i_axil.wdata;
                w_strb_r <= i_axil.wstrb;
            end
            if (do_write) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            end else if (bvalid_r && i_axil.bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control, compare and interrupt registers
    logic [15:0] ctrl_r;
    logic [CMP_W-1:0] period_r;
    logic [N_IRQ-1:0] status_r;
    logic [N_IRQ-1:0] mask_r;
    logic [N_OUT-1:0] pin_func_r;
    logic [CMP_W-1:0] sw_cmp_r [N_CMP];
    logic [CMP_W-1:0] act_cmp_r [N_CMP];
    logic [CMP_W-1:0] cnt_r;

    wire global_en = ctrl_r[B_GLOBAL_EN];
    wire bridge_mode = ctrl_r[B_BRIDGE_MODE];
    wire direction = ctrl_r[B_DIRECTION];
    wire load_req = ctrl_r[B_LOAD_REQ];
    wire high_off = ctrl_r[B_HIGH_OFF];
    wire invert_all = ctrl_r[B_INVERT];
    wire bridge_en = ctrl_r[B_BRIDGE_EN];
    wire trip_en = ctrl_r[B_TRIP_EN];

    wire trip_evt = trip_en && !trip_lvl_r;
    wire cnt_wrap = global_en && cnt_r == period_r;
    wire load_now = global_en && load_req && cnt_r == CNT_ZERO;
    wire [15:0] ctrl_wr = merge16(ctrl_r, w_data_r, w_strb_r);
    wire [15:0] ctrl_sw = wr_ctrl ? ctrl_wr : ctrl_r;
    wire [N_IRQ-1:0] evt = {cnt_wrap, trip_evt};
    wire [N_IRQ-1:0] w1c = wr_status ? w_data_r[N_IRQ-1:0] : '0;
    wire [N_IRQ-1:0] clr_trip = {1'b0, wr_trip_clr};
    wire [N_IRQ-1:0] status_nxt = (status_r & ~w1c & ~clr_trip) | evt;

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= CTRL_RESET;
            period_r <= PERIOD_RESET;
            status_r <= '0;
            mask_r <= '0;
            pin_func_r <= PIN_FUNC_RESET;
        end else if (i_ce) begin
            ctrl_r <= ctrl_sw;
            if (trip_evt) ctrl_r[B_GLOBAL_EN] <= 1'b0;
            status_r <= status_nxt;
            if (wr_period) period_r <= merge16(period_r, w_data_r, w_strb_r);
            if (wr_mask) mask_r <= w_data_r[N_IRQ-1:0];
            if (wr_pin) pin_func_r <= w_data_r[N_OUT-1:0];
        end
    end

    assign o_irq = |(status_r & mask_r);
    assign o_pin_is_pwm = pin_func_r;

    for (genvar k = 0; k < N_CMP; k++) begin : g_cmp
        wire wr_this = do_write && wsel == SEL_CMP0 + 4'(k);
        always_ff @(posedge i_clk or negedge rst_n) begin
            if (!rst_n) begin
                sw_cmp_r[k] <= CMP_RESET;
                act_cmp_r[k] <= CMP_RESET;
            end else if (i_ce) begin
                if (wr_this) begin
                    sw_cmp_r[k] <= merge16(sw_cmp_r[k], w_data_r, w_strb_r);
                end
                if (load_now) act_cmp_r[k] <= sw_cmp_r[k];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Shared timer and compare waveforms
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= CNT_ZERO;
        end else if (i_ce && global_en) begin
            cnt_r <= cnt_wrap ? CNT_ZERO : cnt_r + CNT_STEP;
        end
    end

    logic [N_OUT-1:0] wave_r;
    for (genvar i = 0; i < N_OUT; i++) begin : g_wave
        localparam int P = (i / 2) * 3;
        localparam int F = P + 1 + (i % 2);
        wire hit_set = cnt_r == act_cmp_r[P];
        wire hit_clr = cnt_r == act_cmp_r[F];
        always_ff @(posedge i_clk or negedge rst_n) begin
            if (!rst_n) begin
                wave_r[i] <= 1'b0;
            end else if (i_ce && global_en) begin
                if (hit_clr) wave_r[i] <= 1'b0;
                else if (hit_set) wave_r[i] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output selection
    wire [1:0] pair0 = wave_r[1:0];
    wire [1:0] pair1 = wave_r[3:2];
    wire [N_OUT-1:0] sel_norm = direction ? {PAT_PAIR_LOW, pair0}
                                          : {pair1, PAT_PAIR_LOW};
    wire [N_OUT-1:0] sel_inv = direction ? {pair1, PAT_PAIR_HIGH}
                                         : {PAT_PAIR_HIGH, pair0};
    wire [N_OUT-1:0] sel_bridge = !bridge_en ? PAT_ALL_HIGH
                                : invert_all ? sel_inv : sel_norm;
    wire [N_OUT-1:0] sel_std = invert_all ? ~wave_r : wave_r;
    wire [N_OUT-1:0] pwm_nxt = !global_en ? PAT_ALL_LOW
                             : high_off ? PAT_HIGH_OFF
                             : bridge_mode ? sel_bridge : sel_std;

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_pwm <= PAT_ALL_LOW;
        end else if (i_ce) begin
            o_pwm <= pwm_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read path
    logic [DATA_W-1:0] rd_val;
    always_comb begin
        rd_val = '0;
        if (rsel >= SEL_CMP0 && rsel < SEL_PERIOD) begin
            rd_val[CMP_W-1:0] = sw_cmp_r[3'(rsel - SEL_CMP0)];
        end
        if (rsel == SEL_CTRL) rd_val[15:0] = ctrl_r;
        if (rsel == SEL_PERIOD) rd_val[CMP_W-1:0] = period_r;
        if (rsel == SEL_STATUS) rd_val[N_IRQ-1:0] = status_r;
        if (rsel == SEL_MASK) rd_val[N_IRQ-1:0] = mask_r;
        if (rsel == SEL_PIN_FUNC) rd_val[N_OUT-1:0] = pin_func_r;
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end else if (i_ce) begin
            if (do_read) begin
                rvalid_r <= 1'b1;
                rdata_r <= rd_val;
                rresp_r <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            end else if (rvalid_r && i_axil.rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    assign o_axil.awready = awready;
    assign o_axil.wready = wready;
    assign o_axil.bvalid = bvalid_r;
    assign o_axil.bresp = bresp_r;
    assign o_axil.arready = arready;
    assign o_axil.rvalid = rvalid_r;
    assign o_axil.rdata = rdata_r;
    assign o_axil.rresp = rresp_r;

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n);

    a_ctrl_reset: assert property (
        $rose(rst_n) |-> ctrl_r == CTRL_RESET && !global_en)
        else $error("control not at reset value");
    a_pin_reset: assert property (
        $rose(rst_n) |-> pin_func_r == PIN_FUNC_RESET)
        else $error("pins not in pwm function");
    a_trip_clear: assert property (
        i_ce && wr_trip_clr && !trip_evt |=> !status_r[S_TRIP])
        else $error("trip not cleared");
    a_high_off: assert property (
        i_ce && global_en && high_off |=> o_pwm == PAT_HIGH_OFF)
        else $error("high side off pattern wrong");
    a_bridge_idle: assert property (
        i_ce && global_en && !high_off && bridge_mode && !bridge_en
        |=> o_pwm == PAT_ALL_HIGH)
        else $error("idle bridge not all high");
    a_dir_normal: assert property (
        i_ce && global_en && !high_off && bridge_mode && bridge_en
        && !invert_all && direction |=> o_pwm[3:2] == PAT_PAIR_LOW
        && o_pwm[1:0] == $past(pair0))
        else $error("normal direction wrong");
    a_dir_invert: assert property (
        i_ce && global_en && !high_off && bridge_mode && bridge_en
        && invert_all && !direction |=> o_pwm[3:2] == PAT_PAIR_HIGH)
        else $error("inverted hold wrong");
    a_rise_zero: assert property (
        i_ce && global_en && cnt_r == act_cmp_r[0]
        && cnt_r != act_cmp_r[1] |=> wave_r[0])
        else $error("output zero missed rise");
    a_fall_zero: assert property (
        i_ce && global_en && cnt_r == act_cmp_r[1] |=> !wave_r[0])
        else $error("output zero missed fall");
    a_rise_two: assert property (
        i_ce && global_en && cnt_r == act_cmp_r[3]
        && cnt_r != act_cmp_r[4] |=> wave_r[2])
        else $error("output two missed rise");
    a_fall_two: assert property (
        i_ce && global_en && cnt_r == act_cmp_r[4] |=> !wave_r[2])
        else $error("output two missed fall");
    a_trip_stop: assert property (
        i_ce && trip_evt |=> (!global_en && status_r[S_TRIP])
        and (i_ce |=> o_pwm == PAT_ALL_LOW))
        else $error("trip did not stop outputs");
    a_load_cmp: assert property (
        i_ce && load_now |=> act_cmp_r[0] == $past(sw_cmp_r[0])
        && act_cmp_r[4] == $past(sw_cmp_r[4]))
        else $error("compare load missed");
    a_timer_step: assert property (
        i_ce && global_en && !cnt_wrap |=> cnt_r == $past(cnt_r) + CNT_STEP)
        else $error("timer did not advance");

    c_trip: cover property (i_ce && trip_evt);
    c_load: cover property (i_ce && load_now);
    c_write_ok: cover property (do_write && wsel != SEL_NONE);
    c_read_err: cover property (do_read && rsel == SEL_NONE);

endmodule : hbridge_pwm_output_select

//--- hbridge_pwm_pkg.sv
package hbridge_pwm_pkg;

    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int CMP_W = 16;
    localparam int N_CMP = 8;
    localparam int N_OUT = 4;
    localparam int N_IRQ = 2;

    // Register byte addresses
    localparam logic [31:0] OFF_CTRL = 32'hffff0f80;
    localparam logic [31:0] OFF_PERIOD = 32'hffff0f90;
    localparam logic [31:0] OFF_TRIP_CLR = 32'hffff0fb8;
    localparam logic [31:0] OFF_STATUS = 32'hffff0fc0;
    localparam logic [31:0] OFF_MASK = 32'hffff0fc4;
    localparam logic [31:0] OFF_PIN_FUNC = 32'hffff0fc8;
    localparam logic [31:0] OFF_CMP [N_CMP] = '{
        32'hffff0f84, 32'hffff0f88, 32'hffff0f8c, 32'hffff0f94,
        32'hffff0f98, 32'hffff0f9c, 32'hffff0fa4, 32'hffff0fa8};

    // Register select codes
    localparam logic [3:0] SEL_CTRL = 4'h0;
    localparam logic [3:0] SEL_CMP0 = 4'h1;
    localparam logic [3:0] SEL_PERIOD = 4'h9;
    localparam logic [3:0] SEL_TRIP_CLR = 4'ha;
    localparam logic [3:0] SEL_STATUS = 4'hb;
    localparam logic [3:0] SEL_MASK = 4'hc;
    localparam logic [3:0] SEL_PIN_FUNC = 4'hd;
    localparam logic [3:0] SEL_NONE = 4'hf;

    // Main control register fields
    localparam logic [15:0] CTRL_RESET = 16'h0012;
    localparam int B_GLOBAL_EN = 0;
    localparam int B_BRIDGE_MODE = 1;
    localparam int B_DIRECTION = 2;
    localparam int B_LOAD_REQ = 3;
    localparam int B_HIGH_OFF = 4;
    localparam int B_INVERT = 5;
    localparam int B_BRIDGE_EN = 9;
    localparam int B_TRIP_EN = 10;

    // Status bits
    localparam int S_TRIP = 0;
    localparam int S_WRAP = 1;

    localparam logic [CMP_W-1:0] CMP_RESET = 16'h0000;
    localparam logic [CMP_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CMP_W-1:0] CNT_STEP = 16'h0001;
    localparam logic [N_OUT-1:0] PIN_FUNC_RESET = 4'hf;
    localparam logic [N_OUT-1:0] PAT_HIGH_OFF = 4'h5;
    localparam logic [N_OUT-1:0] PAT_ALL_HIGH = 4'hf;
    localparam logic [N_OUT-1:0] PAT_ALL_LOW = 4'h0;
    localparam logic [1:0] PAT_PAIR_LOW = 2'h0;
    localparam logic [1:0] PAT_PAIR_HIGH = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } axil_rsp_t;

endpackage : hbridge_pwm_pkg

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
    import hbridge_pwm_pkg::*;

    logic i_clk;
    logic i_reset_n;
    logic i_ce;
    axil_req_t req;
    axil_rsp_t rsp;
    logic trip_n;
    logic fault;
    logic [3:0] pwm;
    logic [3:0] gate;
    logic [3:0] pin_is_pwm;
    logic irq;
    int n_errors;
    int num_checks;
    logic [1:0] last_resp;
    logic [31:0] rd;

    hbridge_pwm_output_select #(
        .PERIOD_RESET(16'h000f)
    ) i_hbridge_pwm_output_select (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_ce(i_ce),
        .i_axil(req),
        .o_axil(rsp),
        .i_trip_n(trip_n),
        .o_pwm(pwm),
        .o_pin_is_pwm(pin_is_pwm),
        .o_irq(irq)
    );

    bridge_driver_model i_bridge_driver_model (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_gate(pwm),
        .i_fault(fault),
        .o_trip_n(trip_n),
        .o_gate(gate)
    );

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = !i_clk;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
            n_errors++;
        end
    endtask : check

    task automatic idle(input int n);
        repeat (n) @(posedge i_clk);
    endtask : idle

    // Handshakes are judged on pre-edge values seen at the rising edge
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        while (n < 50) begin
            @(posedge i_clk);
            n++;
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (req.bready && rsp.bvalid) begin
                last_resp = rsp.bresp;
                break;
            end
        end
        if (n >= 50) begin
            n_errors++;
            give_verdict();
        end
    endtask : axi_write

    task automatic axi_read(input logic [31:0] a, output logic [31:0] d);
        int n;
        n = 0;
        d = 32'h0;
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        while (n < 50) begin
            @(posedge i_clk);
            n++;
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (req.rready && rsp.rvalid) begin
                d = rsp.rdata;
                last_resp = rsp.rresp;
                break;
            end
        end
        if (n >= 50) begin
            n_errors++;
            give_verdict();
        end
    endtask : axi_read

    task automatic wait_irq(input logic lvl);
        int n;
        n = 0;
        while (irq !== lvl && n < 40) begin
            @(posedge i_clk);
            n++;
        end
        if (n >= 40) begin
            n_errors++;
            give_verdict();
        end
    endtask : wait_irq

    // High-time of gates 0, 1, 2 over one full 16-count period
    task automatic duty(output int c0, output int c1, output int c2);
        c0 = 0;
        c1 = 0;
        c2 = 0;
        repeat (16) begin
            @(posedge i_clk);
            c0 += int'(gate[0] === 1'b1);
            c1 += int'(gate[1] === 1'b1);
            c2 += int'(gate[2] === 1'b1);
        end
    endtask : duty

    ////////////////////////////////////////////////////////////////////
    logic [15:0] sel_ctrl [7] = '{16'h0003, 16'h0013, 16'h0213, 16'h0203,
        16'h0207, 16'h0223, 16'h0227};
    logic [3:0] sel_exp [7] = '{4'hf, 4'h5, 4'h5, 4'h0, 4'h0, 4'hc, 4'h3};
    logic [3:0] sel_msk [7] = '{4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hc, 4'h3};

    initial begin
        int c0;
        int c1;
        int c2;
        n_errors = 0;
        num_checks = 0;
        i_reset_n = 1'b0;
        i_ce = 1'b1;
        req = '0;
        fault = 1'b0;
        idle(16);
        i_reset_n <= 1'b1;
        idle(3);
        axi_read(OFF_CTRL, rd);
        check(rd, 32'h0000_0012);
        check({28'h0, pin_is_pwm}, 32'h0000_000f);
        axi_read(OFF_PIN_FUNC, rd);
        check(rd, 32'h0000_000f);
        check({28'h0, pwm}, 32'h0);
        axi_read(32'hffff0ffc, rd);
        check({30'h0, last_resp}, {30'h0, RESP_SLVERR});
        axi_write(32'hffff0ffc, 32'h1);
        check({30'h0, last_resp}, {30'h0, RESP_SLVERR});
        for (int i = 0; i < N_CMP; i++) begin
            axi_read(OFF_CMP[i], rd);
            check(rd, 32'h0);
            axi_write(OFF_CMP[i], 32'habcd_0000 | 32'(i * 17));
            axi_read(OFF_CMP[i], rd);
            check(rd, 32'(i * 17));
        end
        // Internal compares still zero here, so all four waves stay low
        for (int i = 0; i < 7; i++) begin
            axi_write(OFF_CTRL, {16'h0, sel_ctrl[i]});
            idle(6);
            check({28'h0, pwm & sel_msk[i]}, {28'h0, sel_exp[i]});
        end
        axi_write(OFF_CTRL, 32'h0000_0012);
        idle(6);
        check({28'h0, pwm}, 32'h0);
        axi_write(OFF_CMP[0], 32'h2);
        axi_write(OFF_CMP[1], 32'h6);
        axi_write(OFF_CMP[2], 32'h8);
        axi_write(OFF_CMP[3], 32'h4);
        axi_write(OFF_CMP[4], 32'ha);
        axi_write(OFF_CTRL, 32'h0000_0001);
        idle(40);
        duty(c0, c1, c2);
        check(32'(c0), 32'h0);
        axi_write(OFF_CTRL, 32'h0000_0009);
        idle(40);
        duty(c0, c1, c2);
        check(32'(c0), 32'h4);
        check(32'(c1), 32'h6);
        check(32'(c2), 32'h6);
        // Standard mode with all outputs inverted
        axi_write(OFF_CTRL, 32'h0000_0021);
        idle(4);
        duty(c0, c1, c2);
        check(32'(c0), 32'hc);
        check(32'(c2), 32'ha);
        // Clock enable low freezes the outputs
        i_ce <= 1'b0;
        idle(2);
        duty(c0, c1, c2);
        check(32'(c0 % 16), 32'h0);
        i_ce <= 1'b1;
        axi_write(OFF_CTRL, 32'h0000_0001);
        axi_write(OFF_CMP[1], 32'h3);
        idle(40);
        duty(c0, c1, c2);
        check(32'(c0), 32'h4);
        axi_write(OFF_MASK, 32'h1);
        axi_write(OFF_CTRL, 32'h0000_0401);
        fault <= 1'b1;
        wait_irq(1'b1);
        check({31'h0, irq}, 32'h1);
        idle(4);
        check({28'h0, pwm}, 32'h0);
        axi_read(OFF_CTRL, rd);
        check(rd, 32'h0000_0400);
        axi_read(OFF_STATUS, rd);
        check(rd & 32'h1, 32'h1);
        fault <= 1'b0;
        idle(10);
        axi_write(OFF_TRIP_CLR, 32'h0000_005a);
        wait_irq(1'b0);
        check({31'h0, irq}, 32'h0);
        axi_read(OFF_STATUS, rd);
        check(rd & 32'h1, 32'h0);
        axi_write(OFF_MASK, 32'h0);
        axi_write(OFF_CTRL, 32'h0000_0401);
        fault <= 1'b1;
        idle(20);
        check({31'h0, irq}, 32'h0);
        fault <= 1'b0;
        idle(10);
        axi_write(OFF_MASK, 32'h1);
        wait_irq(1'b1);
        check({31'h0, irq}, 32'h1);
        axi_write(OFF_STATUS, 32'h1);
        wait_irq(1'b0);
        check({31'h0, irq}, 32'h0);
        give_verdict();
    end
endmodule : testbench
